/* rtl/i2c_slave_scr.sv */
// I2C slave byte engine with status/control register on APB
//
// Our own choice: the APB register port.
`timescale 1ns/100ps

module i2c_slave_scr
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe_n,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  output logic                   irq_req
);

  // Byte addresses need ten bits at least
  generate
    if (ADDR_W < 10)
    begin : g_chk
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction

  typedef struct packed {
    logic                             scl_s1;
    logic                             scl_s2;
    logic                             scl_d;
    logic                             sda_s1;
    logic                             sda_s2;
    logic                             sda_d;
    i2c_slave_scr_pkg::state_type     state;
    logic [3:0]                       bit_cnt;
    logic [7:0]                       shift;
    logic                             data_tx;
    logic                             phase;
    logic                             write_pend;
    logic                             was_tx;
    logic                             was_addr;
    logic                             ack_sent;
    logic                             start_seen;
    logic                             sda_low;
    logic                             scl_hold;
    logic [7:0]                       scr;
    logic [7:0]                       cfg;
    logic                             irq;
    logic [31:0]                      rdata;
    logic                             rerr;
  } state_all_type;

  state_all_type r_reg;
  state_all_type r_next;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ready_first;
  logic wr_cycle;
  logic setup_cycle;
  logic hit_cfg;
  logic hit_scr;
  logic hit_data;

  // Edges and bus conditions from the synchronised pins
  assign scl_rise  = r_reg.scl_s2 & ~r_reg.scl_d;
  assign scl_fall  = ~r_reg.scl_s2 & r_reg.scl_d;
  assign start_det = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
  assign stop_det  = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;

  // Start or Stop is legal only here; in the high phase of a new byte's
  // first bit, the rise of that bit has already been counted
  assign ready_first = (r_reg.state == i2c_slave_scr_pkg::ST_IDLE)
                     | (r_reg.state == i2c_slave_scr_pkg::ST_IGNORE)
                     | ((r_reg.state == i2c_slave_scr_pkg::ST_DATA)
                        & ~r_reg.data_tx
                        & (r_reg.bit_cnt <= i2c_slave_scr_pkg::CNT_ONE));

  // APB decode
  assign setup_cycle = psel & ~penable;
  assign wr_cycle    = psel & penable & pwrite;
  assign hit_cfg  = paddr == reg_addr(i2c_slave_scr_pkg::IDX_CFG);
  assign hit_scr  = paddr == reg_addr(i2c_slave_scr_pkg::IDX_SCR);
  assign hit_data = paddr == reg_addr(i2c_slave_scr_pkg::IDX_DATA);

  // Next-state logic for the whole block
  always_comb
  begin
    r_next        = r_reg;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d  = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d  = r_reg.sda_s2;
    r_next.irq    = 1'b0;

    // Read data captured in the setup phase
    // no read effect
    if (setup_cycle)
    begin
      r_next.rerr  = ~(hit_cfg | hit_scr | hit_data);
      r_next.rdata = 32'h0000_0000;
      if (hit_cfg)
        r_next.rdata[7:0] = r_reg.cfg;
      else if (hit_scr)
        r_next.rdata[7:0] = r_reg.scr;
      else if (hit_data)
        r_next.rdata[7:0] = r_reg.shift;
    end

    // Configuration survives the enable reset
    if (wr_cycle && hit_cfg)
    begin
      r_next.cfg = pwdata[7:0];
    end

    // Data register load from firmware
    if (wr_cycle && hit_data)
    begin
      r_next.shift = pwdata[7:0];
    end

    // Status/control write
    if (wr_cycle && hit_scr)
    begin
      if (!pwdata[i2c_slave_scr_pkg::BIT_BUS_ERR])
        r_next.scr[i2c_slave_scr_pkg::BIT_BUS_ERR] = 1'b0;
      if (!pwdata[i2c_slave_scr_pkg::BIT_ADDR])
        r_next.scr[i2c_slave_scr_pkg::BIT_ADDR] = 1'b0;
      if (!pwdata[i2c_slave_scr_pkg::BIT_LRB])
        r_next.scr[i2c_slave_scr_pkg::BIT_LRB] = 1'b0;
      if (!pwdata[i2c_slave_scr_pkg::BIT_BC])
        r_next.scr[i2c_slave_scr_pkg::BIT_BC] = 1'b0;
      if (!pwdata[i2c_slave_scr_pkg::BIT_STOP]
          && r_reg.scr[i2c_slave_scr_pkg::BIT_BC])
        r_next.scr[i2c_slave_scr_pkg::BIT_STOP] = 1'b0;
      r_next.scr[i2c_slave_scr_pkg::BIT_ACK] =
        pwdata[i2c_slave_scr_pkg::BIT_ACK];
      r_next.scr[i2c_slave_scr_pkg::BIT_TX] =
        pwdata[i2c_slave_scr_pkg::BIT_TX];
      if (r_reg.cfg[i2c_slave_scr_pkg::CFG_COMPAT] && r_reg.start_seen
          && !pwdata[i2c_slave_scr_pkg::BIT_ADDR])
      begin
        r_next.start_seen = 1'b0;
        r_next.state      = i2c_slave_scr_pkg::ST_IGNORE;
      end
      if (r_reg.state == i2c_slave_scr_pkg::ST_HOLD)
      begin
        r_next.write_pend = 1'b1;
        if (r_reg.was_tx && r_reg.scr[i2c_slave_scr_pkg::BIT_LRB])
        begin
          r_next.state    = i2c_slave_scr_pkg::ST_IDLE;
          r_next.scl_hold = 1'b0;
        end
      end
    end

    // Bus events; hardware sets win over a same-cycle clear
    if (start_det)
    begin
      if (!ready_first)
      begin
        r_next.scr[i2c_slave_scr_pkg::BIT_BUS_ERR] = 1'b1;
        r_next.irq = 1'b1;
      end
      r_next.scr[i2c_slave_scr_pkg::BIT_TX]  = 1'b0;
      r_next.scr[i2c_slave_scr_pkg::BIT_LRB] = 1'b0;
      r_next.scr[i2c_slave_scr_pkg::BIT_BC]  = 1'b0;
      r_next.state      = i2c_slave_scr_pkg::ST_ADDR;
      r_next.bit_cnt    = i2c_slave_scr_pkg::CNT_ZERO;
      r_next.data_tx    = 1'b0;
      r_next.start_seen = 1'b1;
      r_next.sda_low    = 1'b0;
      r_next.scl_hold   = 1'b0;
      r_next.phase      = 1'b0;
      r_next.write_pend = 1'b0;
    end
    else if (stop_det)
    begin
      if (!ready_first)
      begin
        r_next.scr[i2c_slave_scr_pkg::BIT_BUS_ERR] = 1'b1;
        r_next.irq = 1'b1;
      end
      if (r_reg.cfg[i2c_slave_scr_pkg::CFG_STOP_IRQ_ENABLE]
          && !r_reg.scr[i2c_slave_scr_pkg::BIT_STOP])
        r_next.irq = 1'b1;
      r_next.scr[i2c_slave_scr_pkg::BIT_STOP] = 1'b1;
      r_next.state      = i2c_slave_scr_pkg::ST_IDLE;
      r_next.sda_low    = 1'b0;
      r_next.scl_hold   = 1'b0;
      r_next.start_seen = 1'b0;
    end
    else
    begin
      unique case (r_reg.state)
        i2c_slave_scr_pkg::ST_IDLE,
        i2c_slave_scr_pkg::ST_IGNORE:
        begin
          r_next.sda_low  = 1'b0;
          // Idle never stalls; a NACK-idle write leaves no clock held
          r_next.scl_hold = 1'b0;
        end
        i2c_slave_scr_pkg::ST_ADDR,
        i2c_slave_scr_pkg::ST_DATA:
        begin
          if (scl_rise && r_reg.bit_cnt < i2c_slave_scr_pkg::BYTE_BITS)
          begin
            r_next.shift   = {r_reg.shift[6:0], r_reg.sda_s2};
            r_next.bit_cnt = r_reg.bit_cnt + i2c_slave_scr_pkg::CNT_ONE;
          end
          // Transmit drives the next bit in the low phase
          if (scl_fall && r_reg.data_tx)
          begin
            r_next.sda_low = (r_reg.bit_cnt < i2c_slave_scr_pkg::BYTE_BITS)
                           & ~r_reg.shift[7];
          end
          if (scl_rise && !r_reg.data_tx
              && r_reg.bit_cnt == i2c_slave_scr_pkg::BYTE_BITS - 4'h1)
          begin
            r_next.was_tx   = 1'b0;
            r_next.was_addr = r_reg.state == i2c_slave_scr_pkg::ST_ADDR;
            if (r_reg.state == i2c_slave_scr_pkg::ST_ADDR)
              r_next.scr[i2c_slave_scr_pkg::BIT_ADDR] = 1'b1;
            r_next.scr[i2c_slave_scr_pkg::BIT_BC]  = 1'b1;
            r_next.scr[i2c_slave_scr_pkg::BIT_ACK] = 1'b0;
            r_next.irq        = 1'b1;
            r_next.start_seen = 1'b0;
            r_next.state      = i2c_slave_scr_pkg::ST_HOLD;
            r_next.phase      = 1'b0;
            r_next.write_pend = 1'b0;
          end
          if (scl_rise && r_reg.data_tx
              && r_reg.bit_cnt == i2c_slave_scr_pkg::BYTE_BITS)
          begin
            r_next.scr[i2c_slave_scr_pkg::BIT_LRB] = r_reg.sda_s2;
            r_next.scr[i2c_slave_scr_pkg::BIT_BC]  = 1'b1;
            r_next.scr[i2c_slave_scr_pkg::BIT_ACK] = 1'b0;
            r_next.was_tx     = 1'b1;
            r_next.was_addr   = 1'b0;
            r_next.irq        = 1'b1;
            r_next.state      = i2c_slave_scr_pkg::ST_HOLD;
            r_next.phase      = 1'b0;
            r_next.write_pend = 1'b0;
          end
        end
        i2c_slave_scr_pkg::ST_HOLD:
        begin
          if (scl_fall)
            r_next.phase = 1'b1;
          r_next.scl_hold = (r_reg.phase | scl_fall) & ~r_reg.write_pend;
          // Continue in the low phase once firmware has written
          if ((r_reg.phase || scl_fall) && r_reg.write_pend)
          begin
            r_next.scl_hold   = 1'b0;
            r_next.phase      = 1'b0;
            r_next.write_pend = 1'b0;
            r_next.bit_cnt    = i2c_slave_scr_pkg::CNT_ZERO;
            if (!r_reg.was_tx)
            begin
              r_next.ack_sent = r_reg.scr[i2c_slave_scr_pkg::BIT_ACK];
              r_next.sda_low  = r_reg.scr[i2c_slave_scr_pkg::BIT_ACK];
              r_next.state    = i2c_slave_scr_pkg::ST_ACK;
            end
            else
            begin
              r_next.data_tx = r_reg.scr[i2c_slave_scr_pkg::BIT_TX];
              r_next.sda_low = r_reg.scr[i2c_slave_scr_pkg::BIT_TX]
                             & ~r_reg.shift[7];
              r_next.state   = i2c_slave_scr_pkg::ST_DATA;
            end
          end
        end
        i2c_slave_scr_pkg::ST_ACK:
        begin
          if (scl_rise)
            r_next.phase = 1'b1;
          if (scl_fall && r_reg.phase)
          begin
            r_next.phase   = 1'b0;
            r_next.bit_cnt = i2c_slave_scr_pkg::CNT_ZERO;
            if (!r_reg.ack_sent)
            begin
              r_next.sda_low = 1'b0;
              r_next.state   = i2c_slave_scr_pkg::ST_IGNORE;
            end
            else
            begin
              r_next.data_tx = r_reg.scr[i2c_slave_scr_pkg::BIT_TX];
              r_next.sda_low = r_reg.scr[i2c_slave_scr_pkg::BIT_TX]
                             & ~r_reg.shift[7];
              r_next.state   = i2c_slave_scr_pkg::ST_DATA;
            end
          end
        end
        default:
        begin
          r_next.state = i2c_slave_scr_pkg::ST_IDLE;
        end
      endcase
    end

    // Spare bit reads zero
    // spare bit zero
    r_next.scr[i2c_slave_scr_pkg::BIT_SPARE] = 1'b0;

    // Block disable holds bus state, status/control and interrupt in reset; configuration and data register keep their values
    if (!r_reg.cfg[i2c_slave_scr_pkg::CFG_EN])
    begin
      r_next.state      = i2c_slave_scr_pkg::ST_IDLE;
      r_next.bit_cnt    = i2c_slave_scr_pkg::CNT_ZERO;
      r_next.scr        = i2c_slave_scr_pkg::SCR_RESET;
      r_next.data_tx    = 1'b0;
      r_next.phase      = 1'b0;
      r_next.write_pend = 1'b0;
      r_next.start_seen = 1'b0;
      r_next.sda_low    = 1'b0;
      r_next.scl_hold   = 1'b0;
      r_next.irq        = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_reg            <= '0;
      r_reg.scl_s1     <= 1'b1;
      r_reg.scl_s2     <= 1'b1;
      r_reg.scl_d      <= 1'b1;
      r_reg.sda_s1     <= 1'b1;
      r_reg.sda_s2     <= 1'b1;
      r_reg.sda_d      <= 1'b1;
      r_reg.state      <= i2c_slave_scr_pkg::ST_IDLE;
      r_reg.shift      <= i2c_slave_scr_pkg::DATA_RESET;
      r_reg.scr        <= i2c_slave_scr_pkg::SCR_RESET;
      r_reg.cfg        <= i2c_slave_scr_pkg::CFG_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs; open-drain pins only ever pull low
  assign prdata   = r_reg.rdata;
  assign pslverr  = r_reg.rerr;
  assign pready   = 1'b1;
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~r_reg.scl_hold;
  assign sda_oe_n = ~r_reg.sda_low;
  assign irq_req  = r_reg.irq;

endmodule

/* rtl/i2c_slave_scr_pkg.sv */
// Constants and types for the I2C slave status and control block
package i2c_slave_scr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CFG       = 8'hD6;
  localparam logic [7:0]  IDX_SCR       = 8'hD7;
  localparam logic [7:0]  IDX_DATA      = 8'hD8;

  // Transfer status/control field positions
  localparam int          BIT_BUS_ERR   = 7;
  localparam int          BIT_SPARE     = 6;
  localparam int          BIT_STOP      = 5;
  localparam int          BIT_ACK       = 4;
  localparam int          BIT_ADDR      = 3;
  localparam int          BIT_TX        = 2;
  localparam int          BIT_LRB       = 1;
  localparam int          BIT_BC        = 0;

  // Configuration field positions
  localparam int          CFG_EN        = 0;
  localparam int          CFG_COMPAT    = 1;
  localparam int          CFG_STOP_IRQ_ENABLE   = 4;

  // Reset values and counts
  localparam logic [7:0]  SCR_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;

  // Bus-facing state of the slave
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DATA   = 3'b010,
    ST_HOLD   = 3'b011,
    ST_ACK    = 3'b100,
    ST_IGNORE = 3'b101
  } state_type;

endpackage

/* verif/i2c_master_model.sv */
// Behavioural I2C bus master on open-drain clock and data
`timescale 1ns/100ps
module i2c_master_model
(
  output logic     scl_drv,
  output logic     sda_drv,
  input wire logic scl_bus,
  input wire logic sda_bus
);
  int timeouts = 0;

  // Bus released at start
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic clk_high;
    int k;
    scl_drv = 1'b1;
    k = 0;
    while (scl_bus !== 1'b1 && k < 400)
    begin
      #10;
      k++;
    end
    if (k == 400)
      timeouts++;
  endtask

  // One bit; 1 releases data, wire sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    #1.3 scl_drv = 1'b0;
    #40 sda_drv = b;
    #40 clk_high();
    #40 s = sda_bus;
    #40 scl_drv = 1'b0;
  endtask

  // Eight bits, most significant first
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
  endtask

  // Start: data falls while clock high
  task automatic start;
    #1.3 sda_drv = 1'b1;
    #40 clk_high();
    #80 sda_drv = 1'b0;
    #80 scl_drv = 1'b0;
  endtask

  // Stop: data rises while clock high
  task automatic stop;
    #1.3 sda_drv = 1'b0;
    #40 clk_high();
    #80 sda_drv = 1'b1;
    #80;
  endtask
endmodule

/* verif/i2c_slave_scr_sva.sv */
// Port-level checks for the I2C slave status/control block
`timescale 1ns/100ps
module i2c_slave_scr_sva
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              scl_in,
  input wire logic              scl_oe_n,
  input wire logic              sda_oe_n,
  input wire logic              irq_req
);
  localparam logic [ADDR_W-1:0] A_CFG  =
    ADDR_W'(4 * i2c_slave_scr_pkg::IDX_CFG);
  localparam logic [ADDR_W-1:0] A_SCR  =
    ADDR_W'(4 * i2c_slave_scr_pkg::IDX_SCR);
  localparam logic [ADDR_W-1:0] A_DATA =
    ADDR_W'(4 * i2c_slave_scr_pkg::IDX_DATA);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Access phase decode
  logic acc;
  logic mapped;
  logic wr_scr;
  assign acc    = psel && penable;
  assign mapped = paddr inside {A_CFG, A_SCR, A_DATA};
  assign wr_scr = acc && pwrite && paddr == A_SCR;

  slverr_map_a : assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not follow the address map");
  spare_zero_a : assert property (acc && !pwrite && paddr == A_SCR
    |-> prdata[6] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("spare or upper read bits not zero");
  stall_release_a : assert property (wr_scr |-> ##[1:3] scl_oe_n)
    else $error("clock stall not released after write");
  stall_cause_a : assert property ($rose(scl_oe_n)
    |-> $past(wr_scr, 1) || $past(wr_scr, 2) || $past(wr_scr, 3))
    else $error("clock stall released without a write");
  stall_low_a : assert property ($fell(scl_oe_n)
    |-> !$past(scl_in, 1) && !$past(scl_in, 2))
    else $error("clock stall began while clock was high");
  irq_pulse_a : assert property (irq_req |=> !irq_req)
    else $error("interrupt request longer than one cycle");
  reset_out_a : assert property ($fell(rst)
    |-> scl_oe_n && sda_oe_n && !irq_req)
    else $error("outputs not idle after reset");
  sda_scl_low_a : assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data drive changed while clock high");
endmodule

bind i2c_slave_scr i2c_slave_scr_sva #(.ADDR_W(ADDR_W)) sva_i
(
  .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .prdata, .pslverr,
  .scl_in, .scl_oe_n, .sda_oe_n, .irq_req
);

/* verif/i2c_slave_status_control_tb.sv */
// Self-checking bench for the I2C slave status/control block
`timescale 1ns/100ps
module i2c_slave_status_control_tb;
  localparam logic [11:0] A_CFG  = 12'(4 * i2c_slave_scr_pkg::IDX_CFG);
  localparam logic [11:0] A_SCR  = 12'(4 * i2c_slave_scr_pkg::IDX_SCR);
  localparam logic [11:0] A_DATA = 12'(4 * i2c_slave_scr_pkg::IDX_DATA);
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err_s, b;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, irq_req;
  logic        scl_drv, sda_drv;
  logic [7:0]  rx;
  wire         scl_bus = scl_drv & scl_oe_n;
  wire         sda_bus = sda_drv & sda_oe_n;
  int          errors  = 0;
  int          n_tests = 0;
  int          irq_n   = 0;

  i2c_slave_scr dut
  (
    .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl_bus), .scl_out, .scl_oe_n,
    .sda_in(sda_bus), .sda_out, .sda_oe_n, .irq_req
  );
  i2c_master_model m
  (
    .scl_drv, .sda_drv, .scl_bus, .sda_bus
  );

  // System clock and interrupt pulse count
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (irq_req === 1'b1)
      irq_n <= irq_n + 1;

  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
    q = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, logic [7:0] e, string what);
    apb(1'b0, a, 8'h00);
    check(what, q, {24'h0, e});
  endtask

  task automatic stalled;
    repeat (10) @(posedge ref_clk);
    check("stall", scl_oe_n, 32'h0);
  endtask

  // Write status/control and see the clock let go
  task automatic go(logic [7:0] d);
    int k;
    apb(1'b1, A_SCR, d);
    k = 0;
    while (scl_oe_n !== 1'b1 && k < 10)
    begin
      @(posedge ref_clk);
      k++;
    end
    check("release", scl_oe_n, 32'h1);
  endtask

  task automatic reg_basics;
    rd(A_SCR, 8'h00, "scr reset");
    apb(1'b0, 12'h004, 8'h00);
    check("unmapped", err_s, 32'h1);
    apb(1'b1, A_CFG, 8'h11);
    check("pin levels", {30'h0, scl_out, sda_out}, 32'h0);
  endtask

  task automatic rx_path;
    m.start();
    m.byte_io(8'hA4, rx);
    stalled();
    rd(A_SCR, 8'h09, "addr st");
    rd(A_SCR, 8'h09, "reread");
    check("irq addr", irq_n, 1);
    go(8'h10);
    m.bit_io(1'b1, b);
    check("addr ack", b, 32'h0);
    m.byte_io(8'h5A, rx);
    stalled();
    rd(A_SCR, 8'h01, "data st");
    rd(A_DATA, 8'h5A, "rx data");
    apb(1'b1, A_SCR, 8'h11);
    rd(A_SCR, 8'h11, "keep bc");
    go(8'h10);
    m.bit_io(1'b1, b);
    check("data ack", b, 32'h0);
    m.stop();
    rd(A_SCR, 8'h30, "stop st");
    check("irq stop", irq_n, 3);
    apb(1'b1, A_SCR, 8'h10);
    rd(A_SCR, 8'h30, "sticky");
  endtask

  task automatic tx_path;
    m.start();
    m.byte_io(8'hA5, rx);
    stalled();
    rd(A_SCR, 8'h29, "rd addr");
    apb(1'b1, A_DATA, 8'h3C);
    go(8'h14);
    m.bit_io(1'b1, b);
    check("rd ack", b, 32'h0);
    m.byte_io(8'hFF, rx);
    check("tx data", rx, 32'h3C);
    m.bit_io(1'b1, b);
    stalled();
    rd(A_SCR, 8'h07, "tx st");
    go(8'h00);
    m.stop();
    rd(A_SCR, 8'h20, "idle stop");
    check("irq tx", irq_n, 6);
  endtask

  task automatic bad_bus;
    m.start();
    repeat (3) m.bit_io(1'b1, b);
    m.stop();
    rd(A_SCR, 8'hA0, "stop err");
    check("irq err", irq_n, 7);
    apb(1'b1, A_SCR, 8'h20);
    rd(A_SCR, 8'h20, "err clr");
    m.start();
    m.byte_io(8'hA4, rx);
    stalled();
    go(8'h00);
    m.bit_io(1'b1, b);
    check("addr nack", b, 32'h1);
    m.byte_io(8'h11, rx);
    repeat (20) @(posedge ref_clk);
    check("irq quiet", irq_n, 8);
    check("no stall", scl_oe_n, 32'h1);
    m.start();
    repeat (3) m.bit_io(1'b1, b);
    m.start();
    rd(A_SCR, 8'h80, "start err");
    // Compat mode: clearing address mid-address drops the start
    apb(1'b1, A_CFG, 8'h13);
    apb(1'b1, A_SCR, 8'h00);
    m.byte_io(8'hA4, rx);
    repeat (20) @(posedge ref_clk);
    check("compat irq", irq_n, 9);
    rd(A_SCR, 8'h00, "compat drop");
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    reg_basics();
    rx_path();
    tx_path();
    bad_bus();
    check("bus hang", m.timeouts, 32'h0);
    tally_and_finish();
  end

  // Run-length bound
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule
